// File: verilog/cpcc_pkg.sv
// Operation
// RL1 - chip select high puts device in standby
// RL2 - chip select high: counter reset, data floats
// RL3 - reload instruction pulses configuration line low
// RL4 - cascade low only when selected, enabled, past limit
// RL5 - cascade returns high on disable or deselect
// RL6 - tap moves on mode select at rising test clock
// RL7 - undriven mode select and test input read one
// RL8 - test clock runs tap and all test logic
// RL9 - every test register shifts from test input
// RL10 - every test register shifts out on test output
// RL11 - counter advances on selected enabled config clock
// RL12 - enable low: counter reset, data floats
// RL13 - enable/reset line held low during power-on reset
// RL14 - bitstream leaves serially on the data output
// RL15 - tap follows the sixteen-state test controller
package cpcc_pkg;
   localparam int          CLK_PERIOD_NS    = 100;
   // power-on reset hold and reload pulse lengths
   localparam int          POR_TIME_NS      = 2000;
   localparam int          POR_CYCLES       = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CFG_PULSE_NS     = 800;
   localparam int          CFG_PULSE_CYCLES = CFG_PULSE_NS / CLK_PERIOD_NS;
   localparam int          CNT_W            = 16;
   // test controller instruction codes
   localparam int          IR_W             = 8;
   localparam logic [7:0]  IR_CAPTURE       = 8'h01;
   localparam logic [7:0]  IR_BYPASS        = 8'hff;
   localparam logic [7:0]  IR_IDCODE        = 8'hfe;
   localparam logic [7:0]  IR_RELOAD        = 8'hee;
   // identity value is arbitrary
   localparam logic [31:0] IDCODE_DEFAULT   = 32'h1234_5001;
   localparam int          WORD_W           = 32;
   localparam int          MEM_DEPTH        = 1024;
   localparam int          FIFO_DEPTH       = 16;

   typedef enum logic [3:0]
   {
      TS_RESET  = 4'h0,
      TS_IDLE   = 4'h1,
      TS_SEL_DR = 4'h3,
      TS_CAP_DR = 4'h2,
      TS_SH_DR  = 4'h6,
      TS_EX1_DR = 4'h7,
      TS_PAU_DR = 4'h5,
      TS_EX2_DR = 4'h4,
      TS_UPD_DR = 4'hc,
      TS_SEL_IR = 4'hd,
      TS_CAP_IR = 4'hf,
      TS_SH_IR  = 4'he,
      TS_EX1_IR = 4'ha,
      TS_PAU_IR = 4'hb,
      TS_EX2_IR = 4'h9,
      TS_UPD_IR = 4'h8
   } cpcc_tap_type;
endpackage

// File: verilog/cpcc_mem.sv
`timescale 1ns/1ps
// bitstream store, one write port, registered read
module cpcc_mem #(
   parameter int W     = 32,
   parameter int DEPTH = 1024,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem_q [DEPTH];

   // no reset on the array, it keeps its contents
   always_ff @(posedge clk)
   begin
      if (we)
         mem_q[waddr] <= wdata;
      rdata <= mem_q[raddr];
   end
endmodule

// File: verilog/cpcc_fifo.sv
`timescale 1ns/1ps
// two-clock fifo, gray pointers cross through two flops each
module cpcc_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic         wr_clk,
   input  wire logic         wr_rst_n,
   input  wire logic         wr_flush,
   input  wire logic         wr_valid,
   output logic              wr_ready,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         rd_clk,
   input  wire logic         rd_rst_n,
   input  wire logic         rd_flush,
   output logic              rd_valid,
   input  wire logic         rd_ready,
   output logic      [W-1:0] rd_data
);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wb_q, wg_q, rb_q, rg_q;
   logic [AW:0]  wg_s1_q, wg_s2_q, rg_s1_q, rg_s2_q;
   logic [AW:0]  wb_d, rb_d;
   logic         push, pop;

   // full compares against the far pointer with its top two bits turned
   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;
   assign wr_ready = wg_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
   assign rd_valid = rg_q != wg_s2_q;
   assign rd_data  = mem_q[rb_q[AW-1:0]];
   assign wb_d     = wb_q + {{AW{1'b0}}, 1'b1};
   assign rb_d     = rb_q + {{AW{1'b0}}, 1'b1};

   always_ff @(posedge wr_clk)
   begin
      if (push)
         mem_q[wb_q[AW-1:0]] <= wr_data;
   end

   // flush only zeroes this side; the far side must flush too
   always_ff @(posedge wr_clk or negedge wr_rst_n)
   begin
      if (!wr_rst_n)
      begin
         wb_q <= '0; wg_q <= '0; rg_s1_q <= '0; rg_s2_q <= '0;
      end
      else
      begin
         rg_s1_q <= rg_q;
         rg_s2_q <= rg_s1_q;
         if (wr_flush)
         begin
            wb_q <= '0; wg_q <= '0;
         end
         else if (push)
         begin
            wb_q <= wb_d; wg_q <= wb_d ^ (wb_d >> 1);
         end
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n)
   begin
      if (!rd_rst_n)
      begin
         rb_q <= '0; rg_q <= '0; wg_s1_q <= '0; wg_s2_q <= '0;
      end
      else
      begin
         wg_s1_q <= wg_q;
         wg_s2_q <= wg_s1_q;
         if (rd_flush)
         begin
            rb_q <= '0; rg_q <= '0;
         end
         else if (pop)
         begin
            rb_q <= rb_d; rg_q <= rb_d ^ (rb_d >> 1);
         end
      end
   end
endmodule

// File: verilog/cpcc_top.sv
`timescale 1ns/1ps
// configuration store with cascade handoff, reload pulse and test port
module cpcc_top
   import cpcc_pkg::*;
#(
   parameter int          W              = WORD_W,
   parameter int          DEPTH          = MEM_DEPTH,
   parameter int          AW             = $clog2(DEPTH),
   parameter logic [31:0] TERMINAL_LIMIT = 32'(DEPTH * W - 1),
   parameter logic [31:0] IDCODE         = IDCODE_DEFAULT
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          config_clk,
   input  wire logic          config_clk_select,
   input  wire logic          chip_select_n,
   input  wire logic          oe_reset_in,
   output logic               oe_reset_out,
   output logic               oe_reset_oe_n,
   output logic               serial_data_out,
   output logic               serial_data_oe_n,
   output logic               cascade_select_out_n,
   output logic               config_pulse_n,
   output logic               config_pulse_oe_n,
   output logic               standby,
   input  wire logic          tck,
   input  wire logic          tms,
   input  wire logic          tms_undriven,
   input  wire logic          tdi,
   input  wire logic          tdi_undriven,
   output logic               tdo_out,
   output logic               tdo_oe_n,
   input  wire logic          prog_we,
   input  wire logic [AW-1:0] prog_addr,
   input  wire logic [W-1:0]  prog_data
);
   localparam int SW = $clog2(W);

   // ---------------- reset release in each domain ----------------
   logic [1:0] rst_k_q, rst_c_q, rst_t_q;
   logic       rst_k_n, rst_c_n, rst_t_n;

   assign rst_k_n = rst_k_q[1];
   assign rst_c_n = rst_c_q[1];
   assign rst_t_n = rst_t_q[1];

   // asynchronous assert, release two edges later in each domain
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) rst_k_q <= 2'h0;
      else        rst_k_q <= {rst_k_q[0], 1'b1};
   end

   always_ff @(posedge config_clk or negedge rst_n)
   begin
      if (!rst_n) rst_c_q <= 2'h0;
      else        rst_c_q <= {rst_c_q[0], 1'b1};
   end

   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n) rst_t_q <= 2'h0;
      else        rst_t_q <= {rst_t_q[0], 1'b1};
   end

   // ---------------- system clock domain ----------------
   logic [1:0]       ce_k_q, oe_k_q, cfg_tgl_k_q;
   logic             cfg_tgl_k3_q, fetch_q;
   logic [CNT_W-1:0] por_cnt_q, cfg_cnt_q;
   logic [AW-1:0]    mem_addr_q;
   logic             por_busy, cfg_drv, cfg_evt, feed_en, can_fetch;
   logic             wr_ready;
   logic [W-1:0]     mem_rdata;
   logic             cfg_tgl_t_q;

   // pins and the reload toggle pass two flops before use
   always_ff @(posedge clk or negedge rst_k_n)
   begin
      if (!rst_k_n)
      begin
         ce_k_q <= 2'h3; oe_k_q <= 2'h0; cfg_tgl_k_q <= 2'h0; cfg_tgl_k3_q <= 1'b0;
      end
      else
      begin
         ce_k_q       <= {ce_k_q[0], chip_select_n};
         oe_k_q       <= {oe_k_q[0], oe_reset_in};
         cfg_tgl_k_q  <= {cfg_tgl_k_q[0], cfg_tgl_t_q};
         cfg_tgl_k3_q <= cfg_tgl_k_q[1];
      end
   end

   assign por_busy  = por_cnt_q != '0;
   assign cfg_drv   = cfg_cnt_q != '0;
   assign cfg_evt   = cfg_tgl_k_q[1] ^ cfg_tgl_k3_q;
   assign standby   = ce_k_q[1];                               // see RL1
   assign feed_en   = !ce_k_q[1] && oe_k_q[1] && !por_busy;
   assign can_fetch = feed_en && wr_ready && !fetch_q;

   // power-on hold, and the fixed-length reload pulse started by each reload toggle
   always_ff @(posedge clk or negedge rst_k_n)
   begin
      if (!rst_k_n)
      begin
         por_cnt_q <= CNT_W'(POR_CYCLES); cfg_cnt_q <= '0;
      end
      else
      begin
         if (por_busy)
            por_cnt_q <= por_cnt_q - 1'b1;                     // see RL13
         if (cfg_evt)
            cfg_cnt_q <= CNT_W'(CFG_PULSE_CYCLES);             // see RL3
         else if (cfg_drv)
            cfg_cnt_q <= cfg_cnt_q - 1'b1;
      end
   end

   // open-drain lines: the out value is a constant low, only enables move
   assign oe_reset_out      = 1'b0;
   assign oe_reset_oe_n     = !por_busy;                       // see RL13
   assign config_pulse_n    = 1'b0;
   assign config_pulse_oe_n = !cfg_drv;                        // see RL3

   // prefetch words whenever the stream is live; idle flushes the fifo
   always_ff @(posedge clk or negedge rst_k_n)
   begin
      if (!rst_k_n)
      begin
         mem_addr_q <= '0; fetch_q <= 1'b0;
      end
      else if (!feed_en)
      begin
         mem_addr_q <= '0; fetch_q <= 1'b0;
      end
      else
      begin
         fetch_q <= can_fetch;
         if (can_fetch)
            mem_addr_q <= mem_addr_q + 1'b1;
      end
   end

   cpcc_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) cpcc_mem_i (
      .clk   (clk),
      .we    (prog_we),
      .waddr (prog_addr),
      .wdata (prog_data),
      .raddr (mem_addr_q),
      .rdata (mem_rdata)
   );

   // ---------------- configuration clock domain ----------------
   logic [1:0]    ce_c_q, oe_c_q, sel_c_q;
   logic [31:0]   bit_cnt_q;
   logic          past_q, sdo_q, hold, run, rd_valid, rd_ready;
   logic [W-1:0]  sh_q, rd_data;

   always_ff @(posedge config_clk or negedge rst_c_n)
   begin
      if (!rst_c_n)
      begin
         ce_c_q <= 2'h3; oe_c_q <= 2'h0; sel_c_q <= 2'h0;
      end
      else
      begin
         ce_c_q  <= {ce_c_q[0], chip_select_n};
         oe_c_q  <= {oe_c_q[0], oe_reset_in};
         sel_c_q <= {sel_c_q[0], config_clk_select};
      end
   end

   // deselect or enable low forces the counter to zero
   assign hold     = ce_c_q[1] || !oe_c_q[1];                  // see RL2 see RL12
   assign run      = sel_c_q[1] && !hold && !past_q;           // see RL11
   assign rd_ready = run && (bit_cnt_q[SW-1:0] == '0);
   assign serial_data_out      = sdo_q;
   assign serial_data_oe_n     = hold || past_q;               // see RL2 see RL12
   assign cascade_select_out_n = !(!hold && past_q);           // see RL4 see RL5

   // counter stops once past the limit so it cannot wrap back
   always_ff @(posedge config_clk or negedge rst_c_n)
   begin
      if (!rst_c_n)
      begin
         bit_cnt_q <= '0; past_q <= 1'b0;
      end
      else if (hold)
      begin
         bit_cnt_q <= '0; past_q <= 1'b0;                      // see RL2
      end
      else if (run)
      begin
         bit_cnt_q <= bit_cnt_q + 32'h1;                       // see RL11
         if (bit_cnt_q == TERMINAL_LIMIT)
            past_q <= 1'b1;                                    // see RL4
      end
   end

   // msb first; an empty fifo at a word boundary repeats the last bit
   always_ff @(posedge config_clk or negedge rst_c_n)
   begin
      if (!rst_c_n)
      begin
         sh_q <= '0; sdo_q <= 1'b0;
      end
      else if (rd_ready && rd_valid)
      begin
         sdo_q <= rd_data[W-1];                                // see RL14
         sh_q  <= {rd_data[W-2:0], 1'b0};
      end
      else if (run && !rd_ready)
      begin
         sdo_q <= sh_q[W-1];                                   // see RL14
         sh_q  <= {sh_q[W-2:0], 1'b0};
      end
   end

   cpcc_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) cpcc_fifo_i (
      .wr_clk   (clk),
      .wr_rst_n (rst_k_n),
      .wr_flush (!feed_en),
      .wr_valid (fetch_q),
      .wr_ready (wr_ready),
      .wr_data  (mem_rdata),
      .rd_clk   (config_clk),
      .rd_rst_n (rst_c_n),
      .rd_flush (hold),
      .rd_valid (rd_valid),
      .rd_ready (rd_ready),
      .rd_data  (rd_data)
   );

   // ---------------- test clock domain ----------------
   cpcc_tap_type      tap_q;
   logic [IR_W-1:0]   ir_q, ir_sh_q;
   logic [31:0]       id_sh_q;
   logic              byp_q, tms_eff, tdi_eff, tdo_q, tdo_oe_n_q;

   function automatic cpcc_tap_type tap_next(input cpcc_tap_type s, input logic m);
      unique case (s)
         TS_RESET:  tap_next = m ? TS_RESET  : TS_IDLE;
         TS_IDLE:   tap_next = m ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR:  tap_next = m ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: tap_next = m ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: tap_next = m ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: tap_next = m ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: tap_next = m ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: tap_next = m ? TS_RESET  : TS_CAP_IR;
         TS_CAP_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR:  tap_next = m ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: tap_next = m ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: tap_next = m ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: tap_next = m ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
      endcase
   endfunction

   // the pad reports a floating line, which then reads as one
   assign tms_eff  = tms_undriven ? 1'b1 : tms;                // see RL7
   assign tdi_eff  = tdi_undriven ? 1'b1 : tdi;                // see RL7
   assign tdo_out  = tdo_q;
   assign tdo_oe_n = tdo_oe_n_q;

   // controller state follows mode select at each rising test clock
   always_ff @(posedge tck or negedge rst_t_n)
   begin
      if (!rst_t_n) tap_q <= TS_RESET;
      else          tap_q <= tap_next(tap_q, tms_eff);         // see RL6 see RL8 see RL15
   end

   // instruction path; reload fires a toggle toward the system clock
   always_ff @(posedge tck or negedge rst_t_n)
   begin
      if (!rst_t_n)
      begin
         ir_sh_q <= '0; ir_q <= IR_IDCODE; cfg_tgl_t_q <= 1'b0;
      end
      else
      begin
         unique case (tap_q)
            TS_RESET:  ir_q    <= IR_IDCODE;
            TS_CAP_IR: ir_sh_q <= IR_CAPTURE;
            TS_SH_IR:  ir_sh_q <= {tdi_eff, ir_sh_q[IR_W-1:1]};  // see RL9
            TS_UPD_IR:
            begin
               ir_q <= ir_sh_q;
               if (ir_sh_q == IR_RELOAD)
                  cfg_tgl_t_q <= !cfg_tgl_t_q;                   // see RL3
            end
            default: ;
         endcase
      end
   end

   // data paths: identity word and the one-bit bypass
   always_ff @(posedge tck or negedge rst_t_n)
   begin
      if (!rst_t_n)
      begin
         id_sh_q <= '0; byp_q <= 1'b0;
      end
      else if (tap_q == TS_CAP_DR)
      begin
         id_sh_q <= IDCODE; byp_q <= 1'b0;
      end
      else if (tap_q == TS_SH_DR)
      begin
         id_sh_q <= {tdi_eff, id_sh_q[31:1]};                  // see RL9
         byp_q   <= tdi_eff;                                   // see RL9
      end
   end

   // falling-edge output so the host samples a settled bit
   always_ff @(negedge tck or negedge rst_t_n)
   begin
      if (!rst_t_n)
      begin
         tdo_q <= 1'b1; tdo_oe_n_q <= 1'b1;
      end
      else
      begin
         tdo_oe_n_q <= !(tap_q == TS_SH_IR || tap_q == TS_SH_DR);
         if (tap_q == TS_SH_IR)
            tdo_q <= ir_sh_q[0];                               // see RL10
         else if (ir_q == IR_IDCODE)
            tdo_q <= id_sh_q[0];                               // see RL10
         else
            tdo_q <= byp_q;                                    // see RL10
      end
   end

   // ---------------- checks ----------------
   property p_standby;
      @(posedge clk) disable iff (!rst_k_n)
      $past(chip_select_n, 2) |-> standby && !feed_en;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not entered"); // see RL1

   property p_hold_cnt;
      @(posedge config_clk) disable iff (!rst_c_n)
      hold |=> bit_cnt_q == 32'h0 && !past_q;
   endproperty
   a_hold_cnt: assert property (p_hold_cnt) else $error("counter not held"); // see RL2

   property p_data_float;
      @(posedge config_clk) disable iff (!rst_c_n)
      $past(chip_select_n, 2) || !$past(oe_reset_in, 2) |-> serial_data_oe_n;
   endproperty
   a_data_float: assert property (p_data_float) else $error("data driven"); // see RL12

   property p_cfg_pulse;
      @(posedge clk) disable iff (!rst_k_n)
      $rose(cfg_drv) |-> cfg_drv[*8] ##1 !cfg_drv;
   endproperty
   a_cfg_pulse: assert property (p_cfg_pulse) else $error("pulse length wrong"); // see RL3

   property p_cascade_low;
      @(posedge config_clk) disable iff (!rst_c_n)
      !cascade_select_out_n |-> !ce_c_q[1] && oe_c_q[1] && bit_cnt_q > TERMINAL_LIMIT;
   endproperty
   a_cascade_low: assert property (p_cascade_low) else $error("cascade low early"); // see RL4

   property p_cascade_high;
      @(posedge config_clk) disable iff (!rst_c_n)
      (ce_c_q[1] || !oe_c_q[1]) |-> cascade_select_out_n ##1 !past_q;
   endproperty
   a_cascade_high: assert property (p_cascade_high) else $error("cascade stuck"); // see RL5

   property p_count;
      @(posedge config_clk) disable iff (!rst_c_n)
      run |=> bit_cnt_q == $past(bit_cnt_q) + 32'h1;
   endproperty
   a_count: assert property (p_count) else $error("counter missed"); // see RL11

   property p_por;
      @(posedge clk) disable iff (!rst_k_n)
      $fell(por_busy) |-> $past(!oe_reset_oe_n) && oe_reset_oe_n;
   endproperty
   a_por: assert property (p_por) else $error("reset line release"); // see RL13

   property p_tap_reset;
      @(posedge tck) disable iff (!rst_t_n)
      tms_eff[*5] |=> tap_q == TS_RESET;
   endproperty
   a_tap_reset: assert property (p_tap_reset) else $error("tap not reset"); // see RL15

   property p_ir_shift;
      @(posedge tck) disable iff (!rst_t_n)
      tap_q == TS_SH_IR |=> ir_sh_q[IR_W-1] == $past(tdi_eff);
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("ir shift wrong"); // see RL9
endmodule

// File: tb/cpcc_host_model.sv
`timescale 1ns/1ps
// far side: configuring logic that clocks bits in, plus a test port host
module cpcc_host_model (
   output logic      config_clk,
   input  wire logic serial_data_out,
   input  wire logic serial_data_oe_n,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_out,
   input  wire logic tdo_oe_n
);
   logic bits_q[$];

   initial
   begin
      config_clk = 1'b0;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // clock runs only inside a frame; a floating data line is kept as z so it never matches
   task automatic clock_bits(input int n);
      for (int i = 0; i < n; i++)
      begin
         #3 config_clk = 1'b1;
         #3 config_clk = 1'b0;
         bits_q.push_back(serial_data_oe_n ? 1'bz : serial_data_out);
      end
   endtask

   // inputs change after the falling edge, output taken at the rising edge
   task automatic tclk(input logic m, input logic din, output logic q);
      tms = m;
      tdi = din;
      #20 tck = 1'b1;
      q = tdo_oe_n ? 1'b1 : tdo_out; // released output reads one through its pull-up
      #20 tck = 1'b0;
   endtask

   // from idle: enter a shift state, shift n bits lsb first, back to idle
   task automatic shift(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
      logic q;
      dout = '0;
      tclk(1'b1, 1'b0, q);
      if (ir)
         tclk(1'b1, 1'b0, q);
      tclk(1'b0, 1'b0, q);
      tclk(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++)
      begin
         tclk(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tclk(1'b1, 1'b0, q);
      tclk(1'b0, 1'b0, q);
   endtask
endmodule

// File: tb/tb_config_prom_cascade_control.sv
`timescale 1ns/1ps
// bench: streaming, cascade handoff, deselect, reload pulse and test port
module tb_config_prom_cascade_control;
   import cpcc_pkg::*;
   localparam logic [31:0] W0 = 32'ha53c_0f1e;
   localparam logic [31:0] W1 = 32'h3c96_e1b7;
   logic        clk, rst_n, sel, cs_n, pull_low, tms_u, tdi_u, we;
   logic [3:0]  addr;
   logic [31:0] wdata, d;
   int          fails, n_compared;
   wire logic   cclk, tck, tms, tdi, oe_out, oe_oe_n, sdo, sdo_oe_n, casc_n;
   wire logic   cfg_n, cfg_oe_n, standby, tdo, tdo_oe_n;
   // open-drain enable line: pulled up unless the store or the bench sinks it
   wire logic   oe_line = !(oe_oe_n === 1'b0 || pull_low);

   // two words only: the limit is set at their last bit to keep frames short
   cpcc_top #(.DEPTH(16), .TERMINAL_LIMIT(32'd63)) cpcc_top_i (
      .clk(clk), .rst_n(rst_n), .config_clk(cclk), .config_clk_select(sel),
      .chip_select_n(cs_n), .oe_reset_in(oe_line), .oe_reset_out(oe_out),
      .oe_reset_oe_n(oe_oe_n), .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n),
      .cascade_select_out_n(casc_n), .config_pulse_n(cfg_n),
      .config_pulse_oe_n(cfg_oe_n), .standby(standby), .tck(tck), .tms(tms),
      .tms_undriven(tms_u), .tdi(tdi), .tdi_undriven(tdi_u), .tdo_out(tdo),
      .tdo_oe_n(tdo_oe_n), .prog_we(we), .prog_addr(addr), .prog_data(wdata));

   cpcc_host_model cpcc_host_model_i (
      .config_clk(cclk), .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo), .tdo_oe_n(tdo_oe_n));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // inputs always move 5 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   // link burst, then back onto the common input phase after a clock edge
   task automatic pulses(input int n);
      cpcc_host_model_i.clock_bits(n);
      step(1);
   endtask

   task automatic frame(input int n);
      cpcc_host_model_i.bits_q.delete();
      pulses(n);
   endtask

   task automatic sh(input logic ir, input int n, input logic [31:0] din);
      cpcc_host_model_i.shift(ir, n, din, d);
   endtask

   // recorded bits from index q0 against word w, msb first from bit b0
   task automatic bits(input int q0, input int n, input logic [31:0] w, input int b0);
      for (int i = 0; i < n; i++)
         check("data bit", {31'h0, w[b0 - i]}, {31'h0, cpcc_host_model_i.bits_q[q0 + i]});
   endtask

   task automatic tap_reset();
      logic q;
      repeat (5) cpcc_host_model_i.tclk(1'b1, 1'b1, q);
      cpcc_host_model_i.tclk(1'b0, 1'b1, q);
   endtask

   task automatic t_por();
      int n;
      n = 0;
      step(3);
      check("power-on hold", 32'h0, {31'h0, oe_oe_n});
      check("reset line level", 32'h0, {31'h0, oe_out});
      while (oe_oe_n !== 1'b1 && n < 40)
      begin
         step(1);
         n++;
      end
      check("power-on length", 32'h1, {31'h0, n >= 16 && n <= 21});
      pulses(4);
      $display("power-on test done");
   endtask

   task automatic t_stream();
      for (int i = 0; i < 2; i++)
      begin
         we = 1'b1;
         addr = 4'(i);
         wdata = i ? W1 : W0;
         step(1);
      end
      we = 1'b0;
      cs_n = 1'b0;
      step(40);
      frame(62);
      check("cascade early", 32'h1, {31'h0, casc_n});
      check("data enable", 32'h0, {31'h0, sdo_oe_n});
      pulses(10);
      bits(2, 32, W0, 31);
      bits(34, 31, W1, 31);
      check("cascade", 32'h0, {31'h0, casc_n});
      check("data float at end", 32'h1, {31'h0, sdo_oe_n});
      $display("stream test done");
   endtask

   task automatic t_deselect();
      cs_n = 1'b1;
      step(3);
      pulses(3);
      check("cascade", 32'h1, {31'h0, casc_n});
      check("data float", 32'h1, {31'h0, sdo_oe_n});
      check("standby", 32'h1, {31'h0, standby});
      cs_n = 1'b0;
      step(40);
      frame(10);
      bits(2, 8, W0, 31);
      check("standby", 32'h0, {31'h0, standby});
      $display("deselect test done");
   endtask

   // hand-off made first, then the enable line is pulled low under it
   task automatic t_oe_low();
      pulses(70);
      check("cascade", 32'h0, {31'h0, casc_n});
      pull_low = 1'b1;
      step(3);
      pulses(3);
      check("cascade", 32'h1, {31'h0, casc_n});
      check("data float", 32'h1, {31'h0, sdo_oe_n});
      pull_low = 1'b0;
      step(40);
      frame(10);
      bits(2, 8, W0, 31);
      $display("enable-low test done");
   endtask

   // an unselected clock must leave the bit standing
   task automatic t_unsel();
      sel = 1'b0;
      step(3);
      frame(10);
      for (int i = 4; i < 10; i++)
         check("held bit", {31'h0, W0[22]}, {31'h0, cpcc_host_model_i.bits_q[i]});
      sel = 1'b1;
      $display("unselected clock test done");
   endtask

   task automatic t_tap();
      logic q;
      tap_reset();
      sh(1'b0, 32, 32'h0);
      check("id value", IDCODE_DEFAULT, d);
      sh(1'b1, 8, {24'h0, IR_BYPASS});
      check("ir capture", 32'h1, d);
      sh(1'b0, 8, 32'h5a);
      check("bypass", 32'hb4, d);
      step(1);
      tdi_u = 1'b1;
      sh(1'b0, 8, 32'h0);
      check("floating input", 32'hfe, d);
      step(1);
      tdi_u = 1'b0;
      tms_u = 1'b1;
      repeat (5) cpcc_host_model_i.tclk(1'b0, 1'b0, q);
      step(1);
      tms_u = 1'b0;
      cpcc_host_model_i.tclk(1'b0, 1'b0, q);
      sh(1'b0, 32, 32'h0);
      check("id after float", IDCODE_DEFAULT, d);
      $display("test port test done");
   endtask

   task automatic t_reload();
      int n;
      n = 0;
      sh(1'b1, 8, {24'h0, IR_RELOAD});
      step(1);
      for (int i = 0; i < 20 && cfg_oe_n !== 1'b0; i++)
         step(1);
      check("pulse level", 32'h0, {31'h0, cfg_n});
      while (cfg_oe_n === 1'b0 && n < 20)
      begin
         step(1);
         n++;
      end
      check("reload pulse", 32'h8, 32'(n));
      $display("reload test done");
   endtask

   initial
   begin
      rst_n = 1'b0;
      sel = 1'b1;
      cs_n = 1'b1;
      pull_low = 1'b0;
      tms_u = 1'b0;
      tdi_u = 1'b0;
      we = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      fails = 0;
      n_compared = 0;
      // every domain sees edges while reset is held
      fork
         step(4);
         begin
            pulses(4);
            tap_reset();
         end
      join
      check("standby in reset", 32'h1, {31'h0, standby});
      rst_n = 1'b1;
      t_por();
      t_stream();
      t_deselect();
      t_oe_low();
      t_unsel();
      t_tap();
      t_reload();
      finish_test();
   end

   // tests need about 25 us; a hang is cut off well beyond that
   initial
   begin
      #300000;
      fails++;
      $display("watchdog expired");
      finish_test();
   end
endmodule
